// File: tb_windowed_watchdog_timer.sv
// Testbench of the windowed watchdog
module tb_windowed_watchdog_timer
  import wwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK = 0, SYS_RST = 1, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, CHANGE_GUARD_OPEN = 0, DEBUG_HALT = 0;
  logic BOOT_FUSE_LOAD = 0, clr_go = 0;
  logic [3:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0, S_AXI_WSTRB = 4'hf, oc = 0;
  logic [2:0] S_AXI_AWPROT = 0, S_AXI_ARPROT = 0;
  logic [31:0] S_AXI_WDATA = 0, d;
  logic [7:0] BOOT_FUSE_SETTING = 0;
  logic [1:0] r;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  wire WDT_RESET_REQ, WATCHDOG_CLEAR_INSTRUCTION, WDT_OSC_CLK;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  int err_count = 0, total_checks = 0, rst_cnt = 0, cyc = 0, n;
  wwd_top u_wwd_top (.*);
  wwd_cpu_model u_wwd_cpu_model (.*);
  always #25 CLOCK = ~CLOCK;
  // Oscillator tick every 16 system cycles
  assign WDT_OSC_CLK = oc[3];
  always @(posedge CLOCK) begin
    oc <= oc + 4'h1;
    cyc <= cyc + 1;
    if (WDT_RESET_REQ === 1'h1) rst_cnt <= rst_cnt + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic ticks(input int k);
    repeat (k * 16) @(posedge CLOCK);
  endtask
  task automatic clr();
    clr_go <= 1'h1;
    @(posedge CLOCK);
    clr_go <= 1'h0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, v};
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    do begin
      @(posedge CLOCK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
    end while ((S_AXI_AWVALID && !S_AXI_AWREADY) || (S_AXI_WVALID && !S_AXI_WREADY));
    do @(posedge CLOCK); while (S_AXI_BVALID !== 1'h1);
    S_AXI_BREADY <= 1'h1;
    @(posedge CLOCK);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    do @(posedge CLOCK); while (S_AXI_ARREADY !== 1'h1);
    S_AXI_ARVALID <= 1'h0;
    do @(posedge CLOCK); while (S_AXI_RVALID !== 1'h1);
    S_AXI_RREADY <= 1'h1;
    @(posedge CLOCK);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'h0;
  endtask
  // Guarded write, status check, wait for crossing end
  task automatic gwr(input logic [3:0] a, input logic [7:0] v, input logic [31:0] e);
    CHANGE_GUARD_OPEN <= 1'h1;
    wr(a, v);
    CHANGE_GUARD_OPEN <= 1'h0;
    chk(r, WWD_RESP_OKAY);
    rd(WWD_ADDR_STAT);
    chk(d, e);
    while (d[0] === 1'h1) rd(WWD_ADDR_STAT);
  endtask
  task automatic t_regs();
    rd(WWD_ADDR_CTRL);
    chk(d, 32'h0);
    rd(4'h8);
    chk(r, WWD_RESP_SLVERR);
    wr(WWD_ADDR_CTRL, 8'h01);
    chk(r, WWD_RESP_OKAY);
    wr(4'h8, 8'h01);
    chk(r, WWD_RESP_SLVERR);
    rd(WWD_ADDR_CTRL);
    chk(d, 32'h0);
    n = rst_cnt;
    ticks(40);
    chk(rst_cnt, n);
  endtask
  task automatic t_norm(input int c);
    int t;
    t = 0;
    gwr(WWD_ADDR_CTRL, 8'(c), 32'h1);
    n = rst_cnt;
    repeat (5) begin
      clr();
      ticks(4);
    end
    chk(rst_cnt, n);
    clr();
    while (rst_cnt == n) begin
      @(posedge CLOCK);
      t++;
    end
    chk(t >= (8 << (c - 1)) * 16 + 16 && t <= (8 << (c - 1)) * 16 + 64, 1);
  endtask
  task automatic t_win();
    gwr(WWD_ADDR_CTRL, 8'h13, 32'h1);
    n = rst_cnt;
    clr();
    repeat (3) @(posedge CLOCK);
    clr();
    ticks(13);
    clr();
    ticks(5);
    chk(rst_cnt, n);
    clr();
    ticks(4);
    chk(rst_cnt, n + 1);
    clr();
    ticks(36);
    chk(rst_cnt, n + 1);
    ticks(10);
    chk(rst_cnt, n + 2);
  endtask
  task automatic t_lock();
    gwr(WWD_ADDR_STAT, 8'h80, 32'h80);
    gwr(WWD_ADDR_CTRL, 8'h00, 32'h80);
    rd(WWD_ADDR_CTRL);
    chk(d, 32'h13);
    gwr(WWD_ADDR_STAT, 8'h00, 32'h80);
    DEBUG_HALT <= 1'h1;
    ticks(1);
    n = rst_cnt;
    ticks(60);
    chk(rst_cnt, n);
    gwr(WWD_ADDR_STAT, 8'h00, 32'h0);
    DEBUG_HALT <= 1'h0;
    n = rst_cnt;
    clr();
    ticks(4);
    chk(rst_cnt, n);
    BOOT_FUSE_SETTING <= 8'h02;
    BOOT_FUSE_LOAD <= 1'h1;
    @(posedge CLOCK);
    BOOT_FUSE_LOAD <= 1'h0;
    rd(WWD_ADDR_CTRL);
    chk(d, 32'h2);
    rd(WWD_ADDR_STAT);
    chk(d[7], 1'h1);
  endtask
  initial begin
    repeat (2) @(posedge CLOCK);
    SYS_RST <= 1'h0;
    @(posedge CLOCK);
    t_regs();
    for (int c = 1; c <= 3; c++) t_norm(c);
    t_win();
    t_lock();
    give_verdict();
  end
endmodule

// File: wwd_chk.sv
// Checker of bus answers and reset request timing
module wwd_chk
  import wwd_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [WWD_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [WWD_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic DEBUG_HALT,
  input wire logic WDT_RESET_REQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dck @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  sequence s_wr;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rd;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  property p_pulse; WDT_RESET_REQ |=> !WDT_RESET_REQ; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  property p_halt; DEBUG_HALT [*4] |-> !WDT_RESET_REQ; endproperty
  a_halt: assert property (p_halt) else $error("reset while halted");
  property p_wr_ans;
    s_wr ##0 (S_AXI_AWADDR == WWD_ADDR_CTRL) |-> ##2 (S_AXI_BVALID && S_AXI_BRESP == 2'h0);
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer wrong");
  property p_rd_ans; s_rd |=> S_AXI_RVALID; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_rd_bad; s_rd ##0 (S_AXI_ARADDR == 4'h8) |=> S_AXI_RRESP == WWD_RESP_SLVERR; endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("unmapped read accepted");
  property p_stat;
    s_rd ##0 (S_AXI_ARADDR == WWD_ADDR_STAT) |=> S_AXI_RDATA[6:1] == 6'h0 && S_AXI_RDATA[31:8] == 24'h0;
  endproperty
  a_stat: assert property (p_stat) else $error("status spare bits set");
  property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule
bind wwd_top wwd_chk u_wwd_chk (.*);

// File: wwd_cpu_model.sv
// CPU core model issuing one-cycle clear instructions
module wwd_cpu_model (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic clr_go,
  output logic WATCHDOG_CLEAR_INSTRUCTION
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) WATCHDOG_CLEAR_INSTRUCTION <= 1'h0;
    else WATCHDOG_CLEAR_INSTRUCTION <= clr_go && !WATCHDOG_CLEAR_INSTRUCTION;
  end
endmodule

// File: wwd_pkg.sv
// Package with register map, field layout and timing constants of the watchdog
package wwd_pkg;
  localparam int unsigned WWD_ADDR_W = 4;
  localparam int unsigned WWD_CNT_W = 14;
  // Register indices; byte address is four times the index
  localparam int unsigned WWD_IDX_CTRL = 0;
  localparam int unsigned WWD_IDX_STAT = 1;
  localparam logic [WWD_ADDR_W-1:0] WWD_ADDR_CTRL = 4'(WWD_IDX_CTRL * 4);
  localparam logic [WWD_ADDR_W-1:0] WWD_ADDR_STAT = 4'(WWD_IDX_STAT * 4);
  // Field positions
  localparam int unsigned WWD_CTRL_PER_LSB = 0;
  localparam int unsigned WWD_CTRL_WIN_LSB = 4;
  localparam int unsigned WWD_STAT_LOCK_BIT = 7;
  localparam int unsigned WWD_STAT_BUSY_BIT = 0;
  // Values after reset
  localparam logic [7:0] WWD_CTRL_RESET = 8'h00;
  localparam logic WWD_LOCK_RESET = 1'b0;
  // Codes
  localparam logic [3:0] WWD_CODE_OFF = 4'h0;
  localparam logic [3:0] WWD_CODE_MAX = 4'hb;
  // Timing: shortest period in microseconds, oscillator rate in hertz
  localparam int unsigned WWD_BASE_TIMEOUT_US = 8000;
  localparam int unsigned WWD_OSC_FREQ_HZ = 1000;
  localparam logic [WWD_CNT_W-1:0] WWD_BASE_TICKS =
    14'(WWD_BASE_TIMEOUT_US * WWD_OSC_FREQ_HZ / 1000000);
  // Oscillator ticks until a crossing completes
  localparam logic [1:0] WWD_SYNC_TICKS = 2'd3;
  // AXI responses
  localparam logic [1:0] WWD_RESP_OKAY = 2'b00;
  localparam logic [1:0] WWD_RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {WWD_ST_OFF, WWD_ST_FIRST, WWD_ST_CLOSED, WWD_ST_OPEN} wwd_state_e;
endpackage

// File: wwd_top.sv
// Windowed watchdog timer with AXI4-Lite register access
// Function
// - Active while time-out field is non-zero
// - Normal mode expiry without clear asserts reset
// - Accepted clear restarts full time-out period
// - Time-out is 8 times 2^(code-1) ticks; codes above 11 act as 11
// - Closed-window field zero selects Normal mode
// - Clear during closed period asserts reset
// - Open follows closed; clear restarts, expiry resets
// - First period after enable/debug is Normal
// - Clear crosses in 2-3 ticks; extras ignored
// - Closed-window field bits 7:4, same scale
// - Freeze bit blocks bus control writes; fuse load still loads
// - Freeze bit written one only; guarded zero write during debug halt clears
// - Fuse loads control; enabled fuse sets freeze
// - Fuse load with non-zero time-out field sets freeze bit
// - Field writes cross over; pending flag shows it
// - Guarded writes only inside unlock window
// - Guarded writes outside window change nothing
// - Debug halt clears and stops the counter
// - Counter runs on 1 kHz oscillator ticks
// - Pending flag clears after crossing completes
module wwd_top
  import wwd_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [WWD_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [WWD_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  input wire logic WDT_OSC_CLK,
  input wire logic WATCHDOG_CLEAR_INSTRUCTION,
  input wire logic CHANGE_GUARD_OPEN,
  input wire logic DEBUG_HALT,
  input wire logic BOOT_FUSE_LOAD,
  input wire logic [7:0] BOOT_FUSE_SETTING,
  output logic WDT_RESET_REQ
);

  function automatic logic [WWD_CNT_W-1:0] ticks_of(input logic [3:0] code);
    logic [3:0] c;
    c = (code > WWD_CODE_MAX) ? WWD_CODE_MAX : code;
    if (code == WWD_CODE_OFF) begin
      return '0;
    end
    return WWD_BASE_TICKS << (c - 4'h1);
  endfunction

  // Register bus state
  logic aw_full_q, w_full_q;
  logic [WWD_ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_strb_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic do_write;

  // Registers
  logic [7:0] ctrl_q;
  logic lock_q;
  logic busy_q;
  logic [1:0] cfg_ticks_q;

  // Oscillator edge detection
  logic osc_s1_q, osc_s2_q, osc_s3_q;
  logic tick;

  // Clear crossing
  logic clr_pend_q;
  logic [1:0] clr_ticks_q;
  logic clr_done;
  logic cfg_done;

  // Watchdog timing
  wwd_state_e state_q;
  logic [WWD_CNT_W-1:0] cnt_q;
  logic [3:0] act_per_q, act_win_q;
  logic [WWD_CNT_W-1:0] open_lim, closed_lim;
  logic expire_open, expire_closed, bad_clear;
  logic rst_req_q;

  assign S_AXI_AWREADY = !aw_full_q;
  assign S_AXI_WREADY = !w_full_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign WDT_RESET_REQ = rst_req_q;

  assign do_write = aw_full_q && w_full_q && !bvalid_q;

  // Write address and data capture, either order
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q <= 1'b0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_full_q <= 1'b0;
      end
      if (S_AXI_WVALID && !w_full_q) begin
        w_full_q <= 1'b1;
        w_data_q <= S_AXI_WDATA[7:0];
        w_strb_q <= S_AXI_WSTRB[0];
      end else if (do_write) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bvalid_q <= 1'b0;
      bresp_q <= WWD_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (aw_addr_q == WWD_ADDR_CTRL || aw_addr_q == WWD_ADDR_STAT) ?
                 WWD_RESP_OKAY : WWD_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= WWD_RESP_OKAY;
    end else if (S_AXI_ARVALID && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= WWD_RESP_OKAY;
      if (S_AXI_ARADDR == WWD_ADDR_CTRL) begin
        rdata_q <= {24'h000000, ctrl_q};
      end else if (S_AXI_ARADDR == WWD_ADDR_STAT) begin
        rdata_q <= {24'h000000, lock_q, 6'h00, busy_q};
      end else begin
        rdata_q <= '0;
        rresp_q <= WWD_RESP_SLVERR;
      end
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // Control register
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_q <= WWD_CTRL_RESET;
    end else if (BOOT_FUSE_LOAD) begin
      ctrl_q <= BOOT_FUSE_SETTING;
    end else if (do_write && aw_addr_q == WWD_ADDR_CTRL && w_strb_q &&
                 CHANGE_GUARD_OPEN && !lock_q) begin
      ctrl_q <= w_data_q;
    end
  end

  // Freeze bit
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lock_q <= WWD_LOCK_RESET;
    end else if (BOOT_FUSE_LOAD) begin
      if (BOOT_FUSE_SETTING[WWD_CTRL_PER_LSB +: 4] != WWD_CODE_OFF) begin
        lock_q <= 1'b1;
      end
    end else if (do_write && aw_addr_q == WWD_ADDR_STAT && w_strb_q && CHANGE_GUARD_OPEN) begin
      if (w_data_q[WWD_STAT_LOCK_BIT]) begin
        lock_q <= 1'b1;
      end else if (DEBUG_HALT) begin
        lock_q <= 1'b0;
      end
    end
  end

  // Oscillator input synchroniser and edge detector
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= WDT_OSC_CLK;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  assign tick = osc_s2_q && !osc_s3_q;

  // Configuration crossing
  assign cfg_done = busy_q && tick && cfg_ticks_q == WWD_SYNC_TICKS - 2'd1;

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      busy_q <= 1'b0;
      cfg_ticks_q <= 2'd0;
    end else if ((do_write && aw_addr_q == WWD_ADDR_CTRL && w_strb_q && CHANGE_GUARD_OPEN &&
                  !lock_q) || BOOT_FUSE_LOAD) begin
      busy_q <= 1'b1;
      cfg_ticks_q <= 2'd0;
    end else if (cfg_done) begin
      busy_q <= 1'b0;
      cfg_ticks_q <= 2'd0;
    end else if (busy_q && tick) begin
      cfg_ticks_q <= cfg_ticks_q + 2'd1;
    end
  end

  // Clear instruction crossing
  assign clr_done = clr_pend_q && tick && clr_ticks_q == WWD_SYNC_TICKS - 2'd1;

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      clr_pend_q <= 1'b0;
      clr_ticks_q <= 2'd0;
    end else if (DEBUG_HALT) begin
      clr_pend_q <= 1'b0;
      clr_ticks_q <= 2'd0;
    end else if (clr_done) begin
      clr_pend_q <= 1'b0;
      clr_ticks_q <= 2'd0;
    end else if (clr_pend_q) begin
      if (tick) begin
        clr_ticks_q <= clr_ticks_q + 2'd1;
      end
    end else if (WATCHDOG_CLEAR_INSTRUCTION) begin
      clr_pend_q <= 1'b1;
      clr_ticks_q <= 2'd0;
    end
  end

  // Period limits and events
  assign open_lim = ticks_of(act_per_q);
  assign closed_lim = ticks_of(act_win_q);
  assign expire_open = tick && !DEBUG_HALT && !clr_done &&
                       (state_q == WWD_ST_FIRST || state_q == WWD_ST_OPEN) &&
                       cnt_q >= open_lim - 14'd1;
  assign expire_closed = tick && !DEBUG_HALT && !clr_done && state_q == WWD_ST_CLOSED &&
                         cnt_q >= closed_lim - 14'd1;
  assign bad_clear = clr_done && !DEBUG_HALT && state_q == WWD_ST_CLOSED;

  // Active configuration after a crossing
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      act_per_q <= WWD_CODE_OFF;
      act_win_q <= WWD_CODE_OFF;
    end else if (cfg_done) begin
      act_per_q <= ctrl_q[WWD_CTRL_PER_LSB +: 4];
      act_win_q <= ctrl_q[WWD_CTRL_WIN_LSB +: 4];
    end
  end

  // Watchdog sequencing; a crossing that keeps the mode lets clears through
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= WWD_ST_OFF;
      cnt_q <= '0;
    end else if (cfg_done && ctrl_q[WWD_CTRL_PER_LSB +: 4] == WWD_CODE_OFF) begin
      state_q <= WWD_ST_OFF;
      cnt_q <= '0;
    end else if (cfg_done && (act_per_q == WWD_CODE_OFF ||
                              (act_win_q == WWD_CODE_OFF &&
                               ctrl_q[WWD_CTRL_WIN_LSB +: 4] != WWD_CODE_OFF))) begin
      state_q <= WWD_ST_FIRST;
      cnt_q <= '0;
    end else if (DEBUG_HALT) begin
      cnt_q <= '0;
      if (state_q != WWD_ST_OFF) begin
        state_q <= WWD_ST_FIRST;
      end
    end else begin
      unique case (state_q)
        WWD_ST_OFF: begin
          cnt_q <= '0;
        end
        WWD_ST_FIRST, WWD_ST_OPEN: begin
          if (clr_done) begin
            cnt_q <= '0;
            state_q <= (act_win_q != WWD_CODE_OFF) ? WWD_ST_CLOSED : WWD_ST_FIRST;
          end else if (expire_open) begin
            cnt_q <= '0;
            state_q <= WWD_ST_FIRST;
          end else if (tick) begin
            cnt_q <= cnt_q + 14'd1;
          end
        end
        WWD_ST_CLOSED: begin
          if (bad_clear) begin
            cnt_q <= '0;
            state_q <= WWD_ST_FIRST;
          end else if (cfg_done && ctrl_q[WWD_CTRL_WIN_LSB +: 4] == WWD_CODE_OFF) begin
            state_q <= WWD_ST_FIRST;
          end else if (expire_closed) begin
            cnt_q <= '0;
            state_q <= WWD_ST_OPEN;
          end else if (tick) begin
            cnt_q <= cnt_q + 14'd1;
          end
        end
      endcase
    end
  end

  // Reset request pulse
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rst_req_q <= 1'b0;
    end else begin
      rst_req_q <= expire_open || bad_clear;
    end
  end

endmodule
